// file: glcs_leg.sv
// One switchover leg of the glitchless clock switch, clocked by its own input
module glcs_leg
  import glcs_pkg::*;
#(
  parameter int STALL_CYCLES = GLCS_STALL_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_choose,
  input wire logic i_other_en,
  output glcs_leg_t o_leg
);

  localparam int CW = $clog2(STALL_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(STALL_CYCLES - 1);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  logic [1:0] choose_q, choose_d;
  logic [1:0] other_q, other_d;
  logic choose_s, other_s;

  // sync latency varies the pulses per stage
  always_comb begin
    choose_d = {choose_q[0], i_choose};
    other_d = {other_q[0], i_other_en};
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      choose_q <= 2'h0;
      other_q <= 2'h0;
    end else begin
      choose_q <= choose_d;
      other_q <= other_d;
    end
  end

  assign choose_s = choose_q[1];
  assign other_s = other_q[1];

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  glcs_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic forced_q, forced_d;

  // Runs on the falling edge so the gate only opens or shuts while low
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    // Mask holds until the other leg lets go, so it never reopens mid-phase
    forced_d = forced_q & other_s;
    case (state_q)
      GLCS_IDLE: begin
        cnt_d = '0;
        if (choose_s) begin
          state_d = other_s ? GLCS_WAIT : GLCS_RUN;
        end
      end
      // wait for old clock to let go
      GLCS_WAIT: begin
        cnt_d = cnt_q + CNT_ONE;
        if (!choose_s) begin
          state_d = GLCS_IDLE;
        end else if (!other_s) begin
          state_d = GLCS_RUN;
        end else if (cnt_q == CNT_LAST) begin
          state_d = GLCS_FORCE;
          forced_d = 1'b1;
        end
      end
      // stuck old clock is cut here
      // output held low for one edge
      GLCS_FORCE: begin
        state_d = choose_s ? GLCS_RUN : GLCS_IDLE;
      end
      // A leg that was cut off gives way once its clock runs again
      GLCS_RUN: begin
        if (!choose_s || (other_s && !forced_q)) begin
          state_d = GLCS_IDLE;
        end
      end
      default: begin
        state_d = GLCS_IDLE;
      end
    endcase
  end

  always_ff @(negedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= GLCS_IDLE;
      cnt_q <= '0;
      forced_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      forced_q <= forced_d;
    end
  end

  // gate straight from the one-hot RUN flop and kill from forced_q, no decode glitch
  // Kill only after a forced cut, so a stuck leg never masks the new one
  assign o_leg.en = state_q[3];
  assign o_leg.kill = forced_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  run_needs_choose_a: assert property (@(negedge i_clk) disable iff (!i_rstn)
    state_q == GLCS_RUN && $past(state_q) != GLCS_RUN |-> $past(choose_s))
    else $error("leg enabled without being chosen");

  force_after_wait_a: assert property (@(negedge i_clk) disable iff (!i_rstn)
    state_q == GLCS_FORCE |-> $past(cnt_q) == CNT_LAST)
    else $error("forced cut before the stall count ran out");

  force_one_edge_a: assert property (@(negedge i_clk) disable iff (!i_rstn)
    state_q == GLCS_FORCE |=> state_q != GLCS_FORCE)
    else $error("forced low phase longer than one edge");

  drop_on_deselect_a: assert property (@(negedge i_clk) disable iff (!i_rstn)
    !choose_s && state_q != GLCS_IDLE |=> state_q == GLCS_IDLE)
    else $error("leg did not release after deselect");

  exclusive_entry_a: assert property (@(negedge i_clk) disable iff (!i_rstn)
    $rose(o_leg.en) |-> !$past(other_s) || $past(state_q) == GLCS_FORCE)
    else $error("leg opened while the other clock was still gated");

  kill_from_force_a: assert property (@(negedge i_clk) disable iff (!i_rstn)
    $rose(o_leg.kill) |-> state_q == GLCS_FORCE)
    else $error("other clock masked without a forced cut");

  normal_switch_c: cover property (@(negedge i_clk) disable iff (!i_rstn)
    state_q == GLCS_WAIT ##[1:20] state_q == GLCS_RUN);
  forced_switch_c: cover property (@(negedge i_clk) disable iff (!i_rstn)
    state_q == GLCS_FORCE ##1 state_q == GLCS_RUN);

endmodule

// file: glcs_top.sv
// Package and top level of the glitchless two-input clock switch
package glcs_pkg;
  localparam int GLCS_REF_PERIOD_NS = 25;
  localparam int GLCS_STARTUP_NS = 1000;
  localparam int GLCS_STARTUP_CYC =
    (GLCS_STARTUP_NS + GLCS_REF_PERIOD_NS - 1) / GLCS_REF_PERIOD_NS;
  localparam int GLCS_STALL_CYC = 8;
  localparam int GLCS_STARTUP_W = 16;

  typedef enum logic [3:0] {
    GLCS_IDLE = 4'h1,
    GLCS_WAIT = 4'h2,
    GLCS_FORCE = 4'h4,
    GLCS_RUN = 4'h8
  } glcs_state_t;

  typedef struct packed {
    logic en;
    logic kill;
  } glcs_leg_t;
endpackage

module glcs_top
  import glcs_pkg::*;
#(
  parameter int STARTUP_CYCLES = GLCS_STARTUP_CYC,
  parameter int STALL_CYCLES = GLCS_STALL_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_clock_in_a,
  input wire logic i_clock_in_b,
  input wire logic i_select,
  input wire logic i_startup_strap,
  input wire logic i_low_swing_a,
  input wire logic i_low_swing_b,
  output logic o_clk,
  output logic o_bypass,
  output logic o_ready
);

  localparam logic [GLCS_STARTUP_W-1:0] ST_LAST =
    GLCS_STARTUP_W'(STARTUP_CYCLES - 1);
  localparam logic [GLCS_STARTUP_W-1:0] ST_ONE = GLCS_STARTUP_W'(1);

  // ---------------------------------------------------------------
  // Reference domain synchronisers
  // ---------------------------------------------------------------
  logic [1:0] strap_q, strap_d;
  logic [1:0] sel_q, sel_d;
  logic [1:0] lsa_q, lsa_d;
  logic [1:0] lsb_q, lsb_d;

  // Pins reach the reference logic through two flops only
  always_comb begin
    strap_d = {strap_q[0], i_startup_strap};
    sel_d = {sel_q[0], i_select};
    lsa_d = {lsa_q[0], i_low_swing_a};
    lsb_d = {lsb_q[0], i_low_swing_b};
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      strap_q <= 2'h0;
      sel_q <= 2'h0;
      lsa_q <= 2'h0;
      lsb_q <= 2'h0;
    end else begin
      strap_q <= strap_d;
      sel_q <= sel_d;
      lsa_q <= lsa_d;
      lsb_q <= lsb_d;
    end
  end

  // ---------------------------------------------------------------
  // Startup delay and strap capture
  // ---------------------------------------------------------------
  logic [GLCS_STARTUP_W-1:0] st_cnt_q, st_cnt_d;
  logic done_q, done_d;
  logic bypass_q, bypass_d;

  // strap is taken once, as the delay ends, then never again
  always_comb begin
    st_cnt_d = st_cnt_q;
    done_d = done_q;
    bypass_d = bypass_q;
    if (!done_q) begin
      st_cnt_d = st_cnt_q + ST_ONE;
      if (st_cnt_q == ST_LAST) begin
        done_d = 1'b1;
        bypass_d = strap_q[1];
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_cnt_q <= '0;
      done_q <= 1'b0;
      bypass_q <= 1'b0;
    end else begin
      st_cnt_q <= st_cnt_d;
      done_q <= done_d;
      bypass_q <= bypass_d;
    end
  end

  // ---------------------------------------------------------------
  // Switchover legs
  // ---------------------------------------------------------------
  glcs_leg_t leg_a, leg_b;
  logic choose_a, choose_b;
  logic busy_a, busy_b;

  // same leg instantiated for each input, cross-coupled
  // Done is static after startup, so gating it before the sync is safe
  assign choose_a = done_q & ~bypass_q & ~i_select;
  assign choose_b = done_q & ~bypass_q & i_select;
  // A leg counts as busy while gated in or masking the other
  assign busy_a = leg_a.en | leg_a.kill;
  assign busy_b = leg_b.en | leg_b.kill;

  glcs_leg #(.STALL_CYCLES(STALL_CYCLES)) u_leg_a (
    .i_clk(i_clock_in_a),
    .i_rstn(i_rstn),
    .i_choose(choose_a),
    .i_other_en(busy_b),
    .o_leg(leg_a)
  );

  glcs_leg #(.STALL_CYCLES(STALL_CYCLES)) u_leg_b (
    .i_clk(i_clock_in_b),
    .i_rstn(i_rstn),
    .i_choose(choose_b),
    .i_other_en(busy_a),
    .o_leg(leg_b)
  );

  // ---------------------------------------------------------------
  // Output path and low-swing hold
  // ---------------------------------------------------------------
  logic gated_clk, plain_clk, raw_clk;
  logic hold_q, hold_d;
  logic level_q, level_d;

  // a leg that cut in masks the stuck clock of the other
  assign gated_clk = (i_clock_in_a & leg_a.en & ~leg_b.kill) |
                     (i_clock_in_b & leg_b.en & ~leg_a.kill);
  // bypass mux follows the choice pin with no staging
  assign plain_clk = i_select ? i_clock_in_b : i_clock_in_a;
  assign raw_clk = bypass_q ? plain_clk : gated_clk;

  // level is sampled at the reference rate; a freeze keeps the
  // last sample, so the held level may lag the true last edge
  always_comb begin
    hold_d = sel_q[1] ? lsb_q[1] : lsa_q[1];
    level_d = hold_q ? level_q : raw_clk;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hold_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
      level_q <= level_d;
    end
  end

  // A clock output cannot come from a flop without halving it
  assign o_clk = hold_q ? level_q : raw_clk;
  assign o_bypass = bypass_q;
  assign o_ready = done_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  bypass_stays_fixed_a: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn) done_q && $past(done_q) |-> $stable(bypass_q))
    else $error("suppressor mode changed after startup");

  startup_release_a: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn) $rose(done_q) |-> $past(st_cnt_q) == ST_LAST)
    else $error("sequencer released before startup delay");

  hold_freezes_a: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn) hold_q && $past(hold_q) |-> $stable(level_q))
    else $error("held level moved while frozen");

  bypass_legs_off_a: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn) bypass_q |-> !leg_a.en && !leg_b.en)
    else $error("a switchover leg opened in plain mux mode");

  legs_wait_ready_a: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn) !done_q |-> !leg_a.en && !leg_b.en)
    else $error("a leg opened before the startup delay ended");

  hold_follows_pin_a: assert property (@(posedge i_ref_clk)
    disable iff (!i_rstn)
    hold_q == $past(sel_q[1] ? lsb_q[1] : lsa_q[1]))
    else $error("freeze did not track the chosen input");

  startup_done_c: cover property (@(posedge i_ref_clk)
    disable iff (!i_rstn) $rose(done_q));
  hold_entered_c: cover property (@(posedge i_ref_clk)
    disable iff (!i_rstn) $rose(hold_q));
  bypass_mode_c: cover property (@(posedge i_ref_clk)
    disable iff (!i_rstn) $rose(bypass_q));

endmodule

// file: glcs_clk_src.sv
// Behavioural clock source for one input of the clock switch
module glcs_clk_src #(
  parameter real HALF_NS = 6.0
) (
  input wire logic i_run,
  input wire logic i_stuck,
  output logic o_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Clock generation
  // ----------------------------------------
  // A stopped source parks at a chosen level, like a failed input
  initial begin
    o_clk = 1'b0;
    forever begin
      #(HALF_NS);
      o_clk = i_run ? ~o_clk : i_stuck;
    end
  end
endmodule

// file: glitchless_clock_switch_tb.sv
// Self-checking testbench of the glitchless clock switch
module glitchless_clock_switch_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, rstn, sel, strap, ls_a, ls_b;
  logic run_a, run_b, stk_a, stk_b, mon_en, held;
  wire logic clk_a, clk_b, o_clk, o_bypass, o_ready;
  int fail_count, n_compared;
  realtime t_last;
  // ----------------------------------------
  // Design and clock sources
  // ----------------------------------------
  // Short startup and stall counts keep the run brief
  glcs_top #(.STARTUP_CYCLES(4), .STALL_CYCLES(3)) u_glcs_top (
    .i_ref_clk(ref_clk), .i_rstn(rstn), .i_clock_in_a(clk_a),
    .i_clock_in_b(clk_b), .i_select(sel), .i_startup_strap(strap),
    .i_low_swing_a(ls_a), .i_low_swing_b(ls_b), .o_clk(o_clk),
    .o_bypass(o_bypass), .o_ready(o_ready));
  // Periods 16 and 12 ns stay inside the 1.5 to 1 ratio
  glcs_clk_src #(.HALF_NS(8.0)) u_glcs_clk_src_a (
    .i_run(run_a), .i_stuck(stk_a), .o_clk(clk_a));
  glcs_clk_src #(.HALF_NS(6.0)) u_glcs_clk_src_b (
    .i_run(run_b), .i_stuck(stk_b), .o_clk(clk_b));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic cmp_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Every output phase while switching must be at least a half period
  always @(o_clk) begin
    if (mon_en) cmp_bit($realtime - t_last >= 5.9, 1'b1);
    t_last = $realtime;
  end
  // Waits until three whole cycles of the chosen input pass through
  task automatic follow(input logic b);
    int n;
    int ok;
    ok = 0;
    for (n = 0; n < 20 && ok < 3; n++) begin
      if (b) @(posedge clk_b);
      else @(posedge clk_a);
      #2 ok = (o_clk === 1'b1) ? ok + 1 : 0;
      if (b) @(negedge clk_b);
      else @(negedge clk_a);
      #2 if (o_clk !== 1'b0) ok = 0;
    end
    cmp_bit(ok == 3, 1'b1);
  endtask
  task automatic start_up();
    int n;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 cmp_bit(o_ready, 1'b0);
    cmp_bit(o_clk, 1'b0);
    for (n = 0; n < 12 && o_ready !== 1'b1; n++) @(posedge ref_clk);
    #1 cmp_bit(o_ready, 1'b1);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic do_switch(input logic b);
    @(posedge ref_clk);
    sel <= b;
    follow(b);
  endtask
  // Input A fails at a level, then B is chosen and A comes back
  task automatic stuck_switch(input logic lvl);
    @(posedge ref_clk);
    run_a <= 1'b0;
    stk_a <= lvl;
    repeat (4) @(posedge ref_clk);
    sel <= 1'b1;
    // Too soon for the new leg to cut in, so the stuck level still shows
    #20 cmp_bit(o_clk, lvl);
    follow(1'b1);
    @(posedge ref_clk);
    run_a <= 1'b1;
    sel <= 1'b0;
    follow(1'b0);
  endtask
  // Lost swing on B must freeze the output while B still toggles
  task automatic freeze();
    do_switch(1'b1);
    mon_en = 1'b0;
    @(posedge ref_clk);
    ls_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 held = o_clk;
    repeat (10) #7 cmp_bit(o_clk, held);
    @(posedge ref_clk);
    ls_b <= 1'b0;
    follow(1'b1);
  endtask
  // Strap high at startup makes a plain multiplexer
  task automatic bypass();
    int i;
    @(posedge ref_clk);
    rstn <= 1'b0;
    strap <= 1'b1;
    start_up();
    cmp_bit(o_bypass, 1'b1);
    for (i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      sel <= i[0];
      repeat (8) @(clk_a or clk_b) #1 cmp_bit(o_clk, sel ? clk_b : clk_a);
    end
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    {rstn, sel, strap, ls_a, ls_b, stk_a, stk_b, mon_en} = 8'h00;
    {run_a, run_b} = 2'h3;
    fail_count = 0;
    n_compared = 0;
    t_last = 0;
    start_up();
    cmp_bit(o_bypass, 1'b0);
    follow(1'b0);
    mon_en = 1'b1;
    do_switch(1'b1);
    do_switch(1'b0);
    stuck_switch(1'b1);
    stuck_switch(1'b0);
    freeze();
    bypass();
    give_verdict();
  end
  // The whole sequence needs a few microseconds at most
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end
endmodule
